/* File: src/psl_pkg.sv */
// constants shared by the start-up configuration loader
package psl_pkg;

	// clocking
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned STEP_FAST_NS    = 2000;
	localparam int unsigned STEP_SLOW_NS    = 4000;
	localparam int unsigned STEP_FAST_CYC   = STEP_FAST_NS / CLK_PERIOD_NS;
	localparam int unsigned STEP_SLOW_CYC   = STEP_SLOW_NS / CLK_PERIOD_NS;
	localparam int unsigned STEP_MV         = 25;
	localparam int unsigned OSC_FAST_HZ     = 16_000_000;
	localparam int unsigned TICK_HZ         = 32_000;
	localparam int unsigned FAST_PER_TICK   = OSC_FAST_HZ / TICK_HZ;
	localparam int unsigned SLOT_SHORT_US   = 500;
	localparam int unsigned SLOT_LONG_US    = 2000;
	localparam int unsigned POWER_ON_RESET_OUT_DELAY_US   = 2000;
	localparam int unsigned SLOT_SHORT_TICK = SLOT_SHORT_US * TICK_HZ / 1_000_000;
	localparam int unsigned SLOT_LONG_TICK  = SLOT_LONG_US * TICK_HZ / 1_000_000;
	localparam int unsigned POWER_ON_RESET_OUT_TICK       = POWER_ON_RESET_OUT_DELAY_US * TICK_HZ / 1_000_000;
	localparam int unsigned SW_DIV_DEFAULT  = 8;

	// register byte offsets
	localparam logic [7:0] OFS_ADDR_CFG = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_MASK     = 8'h08;
	localparam logic [7:0] OFS_STATE    = 8'h0c;
	localparam logic [7:0] OFS_SEQ      = 8'h10;
	localparam logic [7:0] OFS_MISC     = 8'h14;

	// fields
	localparam int unsigned ADDR_USE_DEFAULT_BIT = 7;
	localparam int unsigned ADDR_FIELD_W         = 3;
	localparam logic [3:0]  ADDR_FIXED_HI        = 4'h1;
	localparam logic [6:0]  ADDR_DEFAULT         = 7'h08;
	localparam logic [6:0]  ADDR_LOWEST          = 7'h08;
	localparam logic [6:0]  ADDR_HIGHEST         = 7'h0f;
	localparam logic [7:0]  ADDR_CFG_RESET       = 8'h80;
	localparam int unsigned ST_LOADED    = 0;
	localparam int unsigned ST_SEQ_DONE  = 1;
	localparam int unsigned ST_ADDR_MISS = 2;
	localparam int unsigned ST_W         = 3;
	localparam int unsigned MISC_SLOT_LONG = 0;
	localparam int unsigned MISC_STEP_SLOW = 1;
	localparam int unsigned MISC_EN_EDGE   = 2;
	localparam int unsigned MISC_W         = 3;
	localparam int unsigned SEQ_W          = 4;
	localparam int unsigned NUM_REG_DEFAULT = 8;
	localparam int unsigned THIRD_BUCK_IDX = 2;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		PH_WAIT_SUPPLY,
		PH_LOAD,
		PH_SEQ,
		PH_HOLD,
		PH_DONE
	} psl_phase_type;

endpackage

/* File: src/psl_tick_div.sv */
// enable-pulse divider producing one tick every DIV input enables
`timescale 1ns/1ps
module psl_tick_div #(
	parameter int unsigned DIV = 500
) (
	// clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_reset,
	// enable in, tick out
	input  wire logic i_en,
	output logic      o_tick
);
	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

	initial begin
		if (DIV < 2) $error("psl_tick_div: DIV must be at least 2");
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} psl_div_state_type;

	psl_div_state_type s;
	psl_div_state_type next_s;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (i_en) begin
			if (s.cnt == CW'(DIV - 1)) begin
				next_s.cnt = '0;
				next_s.tick = 1'b1;
			end else begin
				next_s.cnt = s.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_tick = s.tick;
endmodule // psl_tick_div

/* File: src/psl_loader.sv */
// start-up configuration loader with axi4-lite register access
`timescale 1ns/1ps
module psl_loader
	import psl_pkg::*;
#(
	parameter int unsigned NUM_REG = NUM_REG_DEFAULT,
	parameter int unsigned SW_DIV  = SW_DIV_DEFAULT
) (
	// clock and reset
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_reset,
	// axi4-lite slave
	input  wire logic                     i_awvalid,
	output logic                          o_awready,
	input  wire logic [7:0]               i_awaddr,
	input  wire logic                     i_wvalid,
	output logic                          o_wready,
	input  wire logic [31:0]              i_wdata,
	input  wire logic [3:0]               i_wstrb,
	output logic                          o_bvalid,
	input  wire logic                     i_bready,
	output logic [1:0]                    o_bresp,
	input  wire logic                     i_arvalid,
	output logic                          o_arready,
	input  wire logic [7:0]               i_araddr,
	output logic                          o_rvalid,
	input  wire logic                     i_rready,
	output logic [31:0]                   o_rdata,
	output logic [1:0]                    o_rresp,
	// fuse contents
	input  wire logic [NUM_REG*SEQ_W-1:0] i_fuse_seq,
	input  wire logic [MISC_W-1:0]        i_fuse_misc,
	// supply, turn-on and oscillator status
	input  wire logic                     i_undervoltage_detect,
	input  wire logic                     i_turn_on,
	input  wire logic                     i_all_sleep,
	input  wire logic                     i_all_pfm,
	input  wire logic                     i_osc16_on,
	input  wire logic                     i_trim16_tick,
	input  wire logic                     i_untrimmed_tick,
	// i2c address match
	input  wire logic                     i_i2c_addr_strobe,
	input  wire logic [6:0]               i_i2c_addr,
	output logic                          o_i2c_ack,
	output logic [6:0]                    o_slave_addr,
	// regulator control
	output logic [NUM_REG-1:0]            o_reg_enable,
	output logic                          o_half_ref_enable,
	output logic                          o_power_on_reset_out,
	output logic                          o_softstart_step,
	output logic                          o_switch_clk_en,
	// time bases
	output logic                          o_timebase_untrimmed,
	output logic                          o_debounce_tick,
	output logic                          o_button_db_tick,
	output logic                          o_irq_db_tick,
	// interrupt
	output logic                          o_irq
);
	localparam int unsigned SEQ_BITS = NUM_REG * SEQ_W;

	initial begin
		if (SEQ_BITS > 32 || NUM_REG <= THIRD_BUCK_IDX)
			$error("psl_loader: NUM_REG must be 3 to 8");
		if (SW_DIV < 2) $error("psl_loader: SW_DIV must be at least 2");
	end

	typedef struct packed {
		logic                aw_got;
		logic [7:0]          aw_addr;
		logic                w_got;
		logic [31:0]         w_data;
		logic [3:0]          w_strb;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		logic [7:0]          addr_cfg;
		logic [6:0]          slave_addr;
		logic                i2c_ack;
		logic [ST_W-1:0]     status;
		logic [ST_W-1:0]     mask;
		logic                irq;
		logic [SEQ_BITS-1:0] seq;
		logic [MISC_W-1:0]   misc;
		psl_phase_type       phase;
		logic [6:0]          tick_cnt;
		logic [3:0]          slot;
		logic [NUM_REG-1:0]  reg_en;
		logic                power_on_reset_out;
		logic [8:0]          step_cnt;
		logic                step;
		logic                tb_untrimmed;
		logic                db_tick;
		logic                button_tick;
		logic                irq_tick;
	} psl_state_type;

	psl_state_type s;
	psl_state_type next_s;
	logic          tick32;
	logic          sw_tick;

	function automatic logic [3:0] seq_code(input logic [SEQ_BITS-1:0] v, input int unsigned i);
		seq_code = v[i*SEQ_W +: SEQ_W];
	endfunction

	function automatic logic [3:0] last_slot(input logic [SEQ_BITS-1:0] v);
		logic [3:0] m;
		m = '0;
		for (int unsigned i = 0; i < NUM_REG; i++) begin
			if (seq_code(v, i) > m) m = seq_code(v, i);
		end
		last_slot = m;
	endfunction

	function automatic logic [6:0] addr_of(input logic [7:0] cfg);
		if (cfg[ADDR_USE_DEFAULT_BIT]) begin
			addr_of = ADDR_DEFAULT;
		end else begin
			addr_of = {ADDR_FIXED_HI, cfg[ADDR_FIELD_W-1:0]};
		end
	endfunction

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int unsigned b = 0; b < 4; b++) begin
			if (strb[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
		end
		merge_strb = r;
	endfunction

	// derived 32 kHz tick from the trimmed fast oscillator
	psl_tick_div #(
		.DIV (FAST_PER_TICK)
	) u_tick32 (
		.i_clk_sys (i_clk_sys),
		.i_reset   (i_reset),
		.i_en      (i_trim16_tick),
		.o_tick    (tick32)
	);

	// switching clock enable, also from the trimmed fast oscillator
	psl_tick_div #(
		.DIV (SW_DIV)
	) u_swclk (
		.i_clk_sys (i_clk_sys),
		.i_reset   (i_reset),
		.i_en      (i_trim16_tick),
		.o_tick    (sw_tick)
	);

	always_comb begin
		logic [ST_W-1:0]   st_set;
		logic [ST_W-1:0]   st_clr;
		logic [31:0]       wv;
		logic [6:0]        spacing;
		logic [8:0]        step_per;
		logic              good_tb;
		next_s = s;
		st_set = '0;
		st_clr = '0;
		wv = '0;
		good_tb = i_undervoltage_detect && !i_all_sleep && !i_all_pfm;
		spacing = s.misc[MISC_SLOT_LONG] ? 7'(SLOT_LONG_TICK) : 7'(SLOT_SHORT_TICK);
		step_per = s.misc[MISC_STEP_SLOW] ? 9'(STEP_SLOW_CYC) : 9'(STEP_FAST_CYC);
		next_s.step = 1'b0;
		next_s.i2c_ack = 1'b0;

		// write channel: address and data in either order
		if (i_awvalid && s.awready) begin
			next_s.aw_got = 1'b1;
			next_s.aw_addr = i_awaddr;
		end
		if (i_wvalid && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.w_data = i_wdata;
			next_s.w_strb = i_wstrb;
		end
		if (s.bvalid && i_bready) next_s.bvalid = 1'b0;
		if (next_s.aw_got && next_s.w_got && !s.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			wv = merge_strb(32'h0000_0000, next_s.w_data, next_s.w_strb);
			if (next_s.aw_addr[7:2] == OFS_ADDR_CFG[7:2]) begin
				if (next_s.w_strb[0]) next_s.addr_cfg = wv[7:0];
			end else if (next_s.aw_addr[7:2] == OFS_STATUS[7:2]) begin
				st_clr = wv[ST_W-1:0];
			end else if (next_s.aw_addr[7:2] == OFS_MASK[7:2]) begin
				if (next_s.w_strb[0]) next_s.mask = wv[ST_W-1:0];
			end else if (next_s.aw_addr[7:2] == OFS_STATE[7:2]) begin
				next_s.bresp = RESP_OKAY;
			end else if (next_s.aw_addr[7:2] == OFS_SEQ[7:2]) begin
				next_s.seq = SEQ_BITS'(merge_strb(32'(s.seq), next_s.w_data,
					next_s.w_strb));
			end else if (next_s.aw_addr[7:2] == OFS_MISC[7:2]) begin
				if (next_s.w_strb[0]) next_s.misc = wv[MISC_W-1:0];
			end else begin
				next_s.bresp = RESP_SLVERR;
			end
		end
		next_s.awready = !next_s.aw_got && !next_s.bvalid;
		next_s.wready = !next_s.w_got && !next_s.bvalid;

		// read channel
		if (s.rvalid && i_rready) next_s.rvalid = 1'b0;
		if (i_arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			next_s.rdata = '0;
			if (i_araddr[7:2] == OFS_ADDR_CFG[7:2]) begin
				next_s.rdata[7:0] = s.addr_cfg;
			end else if (i_araddr[7:2] == OFS_STATUS[7:2]) begin
				next_s.rdata[ST_W-1:0] = s.status;
			end else if (i_araddr[7:2] == OFS_MASK[7:2]) begin
				next_s.rdata[ST_W-1:0] = s.mask;
			end else if (i_araddr[7:2] == OFS_STATE[7:2]) begin
				next_s.rdata = {16'h0000, s.tb_untrimmed, s.power_on_reset_out, s.slot,
					|s.reg_en, 5'(s.phase), 4'h0};
				next_s.rdata[NUM_REG+15 -: NUM_REG] = s.reg_en;
			end else if (i_araddr[7:2] == OFS_SEQ[7:2]) begin
				next_s.rdata[SEQ_BITS-1:0] = s.seq;
			end else if (i_araddr[7:2] == OFS_MISC[7:2]) begin
				next_s.rdata[MISC_W-1:0] = s.misc;
			end else begin
				next_s.rresp = RESP_SLVERR;
			end
		end
		next_s.arready = !next_s.rvalid;

		// address decode takes effect right at the completing write
		next_s.slave_addr = addr_of(next_s.addr_cfg);
		if (i_i2c_addr_strobe) begin
			if (i_i2c_addr == s.slave_addr) begin
				next_s.i2c_ack = 1'b1;
			end else begin
				st_set[ST_ADDR_MISS] = 1'b1;
			end
		end

		// time base selection
		next_s.tb_untrimmed = !good_tb;
		next_s.db_tick = (i_osc16_on && good_tb) ? tick32 : i_untrimmed_tick;
		next_s.button_tick = s.misc[MISC_EN_EDGE] ? tick32 : next_s.db_tick;
		next_s.irq_tick = i_untrimmed_tick;

		// start-up sequencing, timed only by the derived tick
		case (s.phase)
			PH_WAIT_SUPPLY: begin
				if (i_undervoltage_detect) next_s.phase = PH_LOAD;
			end
			PH_LOAD: begin
				next_s.phase = PH_SEQ;
			end
			PH_SEQ: begin
				if (s.slot == last_slot(s.seq)) begin
					next_s.phase = PH_HOLD;
					next_s.tick_cnt = '0;
				end else if (tick32) begin
					if (s.tick_cnt == spacing - 7'd1) begin
						next_s.tick_cnt = '0;
						next_s.slot = s.slot + 4'd1;
					end else begin
						next_s.tick_cnt = s.tick_cnt + 7'd1;
					end
				end
			end
			PH_HOLD: begin
				if (tick32) begin
					if (s.tick_cnt == 7'(POWER_ON_RESET_OUT_TICK - 1)) begin
						next_s.phase = PH_DONE;
						next_s.power_on_reset_out = 1'b1;
						st_set[ST_SEQ_DONE] = 1'b1;
					end else begin
						next_s.tick_cnt = s.tick_cnt + 7'd1;
					end
				end
			end
			PH_DONE: begin
				next_s.phase = PH_DONE;
			end
			default: begin
				next_s.phase = PH_WAIT_SUPPLY;
			end
		endcase
		for (int unsigned i = 0; i < NUM_REG; i++) begin
			if (seq_code(s.seq, i) != 4'h0 && next_s.slot >= seq_code(s.seq, i)
				&& next_s.phase != PH_LOAD && next_s.phase != PH_WAIT_SUPPLY)
				next_s.reg_en[i] = 1'b1;
		end

		// soft-start step pacing while ramps run
		if (s.phase == PH_SEQ || s.phase == PH_HOLD) begin
			if (s.step_cnt >= step_per - 9'd1) begin
				next_s.step_cnt = '0;
				next_s.step = 1'b1;
			end else begin
				next_s.step_cnt = s.step_cnt + 9'd1;
			end
		end else begin
			next_s.step_cnt = '0;
		end

		// fuse copy on cold start and every turn-on, overriding bus writes
		if (s.phase == PH_LOAD) begin
			next_s.seq = i_fuse_seq;
			next_s.misc = i_fuse_misc;
			st_set[ST_LOADED] = 1'b1;
		end
		if ((i_turn_on && i_undervoltage_detect) || !i_undervoltage_detect) begin
			next_s.phase = i_undervoltage_detect ? PH_LOAD : PH_WAIT_SUPPLY;
			next_s.slot = '0;
			next_s.tick_cnt = '0;
			next_s.reg_en = '0;
			next_s.power_on_reset_out = 1'b0;
		end

		// sticky status, a new event beats a clear in the same cycle
		next_s.status = (s.status & ~st_clr) | st_set;
		next_s.irq = |(next_s.status & next_s.mask);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			s <= '0;
			s.addr_cfg <= ADDR_CFG_RESET;
			s.slave_addr <= ADDR_DEFAULT;
		end else begin
			s <= next_s;
		end
	end

	assign o_awready            = s.awready;
	assign o_wready             = s.wready;
	assign o_bvalid             = s.bvalid;
	assign o_bresp              = s.bresp;
	assign o_arready            = s.arready;
	assign o_rvalid             = s.rvalid;
	assign o_rdata              = s.rdata;
	assign o_rresp              = s.rresp;
	assign o_i2c_ack            = s.i2c_ack;
	assign o_slave_addr         = s.slave_addr;
	assign o_reg_enable         = s.reg_en;
	assign o_half_ref_enable    = s.reg_en[THIRD_BUCK_IDX];
	assign o_power_on_reset_out = s.power_on_reset_out;
	assign o_softstart_step     = s.step;
	assign o_switch_clk_en      = sw_tick;
	assign o_timebase_untrimmed = s.tb_untrimmed;
	assign o_debounce_tick      = s.db_tick;
	assign o_button_db_tick     = s.button_tick;
	assign o_irq_db_tick        = s.irq_tick;
	assign o_irq                = s.irq;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	a_addr_range: assert property (o_slave_addr >= ADDR_LOWEST && o_slave_addr <= ADDR_HIGHEST)
		else $error("slave address out of range");
	a_addr_default: assert property (s.addr_cfg[ADDR_USE_DEFAULT_BIT]
		|-> o_slave_addr == ADDR_DEFAULT)
		else $error("default address not kept");
	a_addr_field: assert property (!s.addr_cfg[ADDR_USE_DEFAULT_BIT]
		|-> o_slave_addr == {ADDR_FIXED_HI, s.addr_cfg[ADDR_FIELD_W-1:0]})
		else $error("address low bits do not follow field");
	a_ack_match: assert property (i_i2c_addr_strobe && i_i2c_addr == o_slave_addr |=> o_i2c_ack)
		else $error("own address not acknowledged");
	a_ack_other: assert property (i_i2c_addr_strobe && i_i2c_addr != o_slave_addr |=> !o_i2c_ack)
		else $error("foreign address acknowledged");
	a_tb_select: assert property (!i_undervoltage_detect || i_all_sleep || i_all_pfm |=> o_timebase_untrimmed)
		else $error("untrimmed base not selected");
	a_irq_tick: assert property (o_irq_db_tick == $past(i_untrimmed_tick))
		else $error("irq debounce not on untrimmed tick");
	a_fuse_copy: assert property (s.phase == PH_LOAD && i_undervoltage_detect && !i_turn_on |=> s.seq == $past(i_fuse_seq))
		else $error("staging not loaded from fuses");
	a_ref_follow: assert property (o_half_ref_enable == o_reg_enable[THIRD_BUCK_IDX])
		else $error("reference slot differs from third buck");
	a_power_on_reset_out_rise: assert property ($rose(o_power_on_reset_out) |-> s.phase == PH_DONE && $past(s.phase) == PH_HOLD)
		else $error("reset output released out of order");
endmodule // psl_loader

/* File: verification/psl_i2c_host.sv */
// host-side model that presents address phases to the loader
`timescale 1ns/1ps
module psl_i2c_host (
	// clock
	input  wire logic i_clk_sys,
	// address phase towards the device
	output logic       o_strobe,
	output logic [6:0] o_addr
);
	initial begin
		o_strobe = 1'b0;
		o_addr   = 7'h00;
	end

	// one strobed address phase; address bus shows junk once released
	task automatic send(input logic [6:0] a);
		@(posedge i_clk_sys);
		o_strobe <= 1'b1;
		o_addr   <= a;
		@(posedge i_clk_sys);
		o_strobe <= 1'b0;
		o_addr   <= ~a;
	endtask
endmodule // psl_i2c_host

/* File: verification/tb.sv */
// self-checking bench for the start-up configuration loader
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
`define WAIT(c) begin n = 0; do begin @(posedge clk); n++; end while (!(c) && n < 60000); end
module tb;
	import psl_pkg::*;
	localparam logic [31:0] FUSE = 32'h0000_0201;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sd  = 1'b0;
	logic        awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, uv, ton, slp, pfm, t32;
	logic        stb, ack, half, por, ss, swc, tbu, dbt, idt, irq, bdt;
	logic [7:0]  awa, ara, en;
	logic [31:0] wd, rdat;
	logic [1:0]  bresp, rresp;
	logic [6:0]  ha, sa;
	logic [33:0] e;
	logic [1:0]  bq[$];
	logic [33:0] rq[$];
	logic        aq[$];
	int          errors = 0;
	int          checked = 0;
	int          n, i, c0, c1, c2, c3;

	always #5 clk = ~clk;

	psl_loader u_dut (.i_clk_sys(clk), .i_reset(rst), .i_awvalid(awv), .o_awready(awr),
		.i_awaddr(awa), .i_wvalid(wv), .o_wready(wrdy), .i_wdata(wd), .i_wstrb(4'hf),
		.o_bvalid(bv), .i_bready(br), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr),
		.i_araddr(ara), .o_rvalid(rv), .i_rready(rr), .o_rdata(rdat), .o_rresp(rresp),
		.i_fuse_seq(FUSE), .i_fuse_misc(3'h2), .i_undervoltage_detect(uv), .i_turn_on(ton),
		.i_all_sleep(slp), .i_all_pfm(pfm), .i_osc16_on(1'b1), .i_trim16_tick(1'b1),
		.i_untrimmed_tick(t32), .i_i2c_addr_strobe(stb), .i_i2c_addr(ha), .o_i2c_ack(ack),
		.o_slave_addr(sa), .o_reg_enable(en), .o_half_ref_enable(half),
		.o_power_on_reset_out(por), .o_softstart_step(ss), .o_switch_clk_en(swc),
		.o_timebase_untrimmed(tbu), .o_debounce_tick(dbt), .o_button_db_tick(bdt),
		.o_irq_db_tick(idt), .o_irq(irq));

	psl_i2c_host u_host (.i_clk_sys(clk), .o_strobe(stb), .o_addr(ha));

	// results are matched against the oldest expectation
	always @(posedge clk) begin
		if (bv && br) `CHK(bresp, bq.pop_front())
		if (rv && rr) begin
			e = rq.pop_front();
			`CHK(rresp, e[33:32])
			if (e[33:32] === RESP_OKAY) `CHK(rdat, e[31:0])
		end
		if (sd) `CHK(ack, aq.pop_front())
		sd <= stb;
	end

	task automatic report_and_stop();
		if (errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int k;
		@(posedge clk);
		bq.push_back(r);
		awv <= 1'b1;
		awa <= a;
		wv  <= 1'b1;
		wd  <= d;
		br  <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
			if (awv && awr) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
		end while (!(bv && br) && k < 200);
		br <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int k;
		@(posedge clk);
		rq.push_back({r, d});
		arv <= 1'b1;
		ara <= a;
		rr  <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
			if (arv && arr) arv <= 1'b0;
		end while (!(rv && rr) && k < 200);
		rr <= 1'b0;
	endtask

	task automatic talk(input logic [6:0] a, input logic x);
		aq.push_back(x);
		u_host.send(a);
	endtask

	initial begin
		repeat (90000) @(posedge clk);
		errors++;
		report_and_stop();
	end

	initial begin
		void'($urandom(48917));
		{awv, wv, br, arv, rr, uv, ton, slp, pfm, t32} = '0;
		awa = '0;
		ara = '0;
		wd  = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_ADDR_CFG, 32'h80, RESP_OKAY);
		`CHK(sa, ADDR_DEFAULT)
		talk(7'h08, 1'b1);
		talk(7'h09, 1'b0);
		for (i = 0; i < 8; i++) begin
			wr(OFS_ADDR_CFG, i, RESP_OKAY);
			`CHK(sa, ADDR_LOWEST + 7'(i))
			talk(ADDR_LOWEST + 7'(i), 1'b1);
			talk(ADDR_LOWEST + 7'((i + 1) % 8), 1'b0);
			talk(7'($urandom_range(127, 16)), 1'b0);
		end
		wr(OFS_ADDR_CFG, 32'h85, RESP_OKAY);
		`CHK(sa, ADDR_DEFAULT)
		talk(7'h0d, 1'b0);
		// miss flag drives the interrupt through the mask
		wr(OFS_MASK, 32'h0, RESP_OKAY);
		rd(OFS_STATUS, 32'h4, RESP_OKAY);
		`CHK(irq, 1'b0)
		wr(OFS_MASK, 32'h4, RESP_OKAY);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		wr(OFS_STATUS, 32'h4, RESP_OKAY);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		wr(8'h20, 32'h0, RESP_SLVERR);
		rd(8'h20, 32'h0, RESP_SLVERR);
		`CHK(tbu, 1'b1)
		// staging written before supply is good must be overwritten
		wr(OFS_SEQ, 32'h777, RESP_OKAY);
		uv <= 1'b1;
		`WAIT(ss)
		`WAIT(ss)
		`CHK(n, STEP_SLOW_CYC)
		`CHK(tbu, 1'b0)
		rd(OFS_SEQ, FUSE, RESP_OKAY);
		rd(OFS_MISC, 32'h2, RESP_OKAY);
		`WAIT(en[0])
		`CHK(en[2], 1'b0)
		`WAIT(en[2])
		`CHK(n > 7990 && n < 8010, 1'b1)
		`CHK(half, 1'b1)
		`CHK(en[1], 1'b0)
		`CHK(por, 1'b0)
		`WAIT(por)
		`CHK(n > 31990 && n < 32010, 1'b1)
		rd(OFS_STATUS, 32'h3, RESP_OKAY);
		rd(OFS_STATE, 32'h0005_4a40, RESP_OKAY);
		wr(OFS_SEQ, 32'h33, RESP_OKAY);
		rd(OFS_SEQ, 32'h33, RESP_OKAY);
		@(posedge clk);
		ton <= 1'b1;
		@(posedge clk);
		ton <= 1'b0;
		repeat (4) @(posedge clk);
		rd(OFS_SEQ, FUSE, RESP_OKAY);
		slp <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(tbu, 1'b1)
		slp <= 1'b0;
		pfm <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(tbu, 1'b1)
		pfm <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(tbu, 1'b0)
		c0 = 0;
		c1 = 0;
		c2 = 0;
		for (i = 0; i < 1000; i++) begin
			@(posedge clk);
			t32 <= (i % 100 == 0);
			c0 += swc;
			c1 += idt;
			c2 += dbt;
		end
		`CHK(c0 >= 124 && c0 <= 126, 1'b1)
		`CHK(c1 >= 9 && c1 <= 11, 1'b1)
		`CHK(c2 >= 1 && c2 <= 3, 1'b1)
		// edge-sensitive button keeps the derived tick while all regulators sleep
		wr(OFS_MISC, 32'h6, RESP_OKAY);
		slp <= 1'b1;
		c2 = 0;
		c3 = 0;
		for (i = 0; i < 1000; i++) begin
			@(posedge clk);
			t32 <= (i % 100 == 0);
			c2 += dbt;
			c3 += bdt;
		end
		`CHK(c2 >= 9 && c2 <= 11, 1'b1)
		`CHK(c3 >= 1 && c3 <= 3, 1'b1)
		report_and_stop();
	end
endmodule // tb
